// [src/ccls_charger_cfg.sv]
/*
  ccls_charger_cfg: charger configuration register bank with input current
  limit selection for a battery charger.
  assumes: a serial control interface upstream decodes transfers into the
  single-cycle register port below; otp defaults are stable at reset release;
  sense inputs are synchronous to clock.
*/
// Overview of operation
// [RQ1] While a dc supply is seen the dc limit field is copied into the active buck limit field.
// [RQ2] With vbus and a dedicated charger detected the usb limit field sets the input limit.
// [RQ3] On a standard usb port the active buck limit field sets the input limit.
// [RQ4] The buck sleep bit puts the charger buck into sleep.
// [RQ5] The buck limit is reduced while the input voltage is below the selected threshold.
// [RQ6] The pre-charge field sets the current for depleted batteries.
// [RQ7] The nominal charge field sets the constant current phase current.
// [RQ8] The target voltage field selects the charge target voltage.
// [RQ9] Software is expected to keep the thermal control bit set.
// [RQ10] The auto-detect bit enables usb charger detection and is chosen by the host.
// [RQ11] The otp default of the buck enable bit is expected to be one.
// [RQ12] The otp default of the buck limit field is expected to be the 100 mA code.
// [RQ13] The charger is activated once the battery thermistor is sensed. The code also requires the buck enable bit to be set.
// [RQ14] Clearing the thermal control bit disables temperature-based current reduction.
// [RQ15] Once the host clears the auto-detect bit the detection stops.
// [RQ16] With d- as a select pin, high picks the usb limit and low the buck limit.
// [RQ17] All fields load their otp defaults before limit selection starts.
`timescale 1ns/10ps
`default_nettype none
module ccls_charger_cfg
  import ccls_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire ccls_cfg_t   otp_defaults,
  input  wire ccls_sense_t sense,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  output logic             cfg_ready,
  output ccls_ctl_t        ctl
);

  ccls_state_t state_q;
  ccls_state_t state_d;
  ccls_cfg_t   cfg_q;
  ccls_cfg_t   cfg_d;
  ccls_sense_t sense_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        rvalid_q;
  logic        ready_q;
  ccls_ctl_t   ctl_q;
  ccls_ctl_t   ctl_d;

  // address decode
  wire hit_buck;
  wire hit_src;
  wire hit_bat;
  wire hit_volt;
  wire running;
  wire wr_buck;
  wire wr_src;
  wire wr_bat;
  wire wr_volt;

  assign hit_buck = (reg_addr == CCLS_IDX_BUCK_CTRL);
  assign hit_src  = (reg_addr == CCLS_IDX_SRC_LIMITS);
  assign hit_bat  = (reg_addr == CCLS_IDX_BAT_CURR);
  assign hit_volt = (reg_addr == CCLS_IDX_VOLT_CTRL);
  assign running  = (state_q == CCLS_ST_RUN);
  assign wr_buck  = running & reg_write & hit_buck;
  assign wr_src   = running & reg_write & hit_src;
  assign wr_bat   = running & reg_write & hit_bat;
  assign wr_volt  = running & reg_write & hit_volt;

  // field views
  wire       therm_en;
  wire       autodet_en;
  wire       sleep_sel;
  wire       buck_en_bit;
  wire [3:0] buck_limit;
  wire [3:0] dc_limit;
  wire [3:0] usb_limit;
  wire [3:0] sel_limit;
  wire [3:0] reduced_limit;

  assign therm_en    = cfg_q.buck_ctrl[CCLS_THERM_EN_BIT];
  assign autodet_en  = cfg_q.buck_ctrl[CCLS_AUTODET_BIT];
  assign sleep_sel   = cfg_q.buck_ctrl[CCLS_SLEEP_BIT];
  assign buck_en_bit = cfg_q.buck_ctrl[CCLS_BUCK_EN_BIT];
  assign buck_limit  = cfg_q.buck_ctrl[CCLS_BUCK_LIM_LSB +: 4];
  assign dc_limit    = cfg_q.src_limits[CCLS_DC_LIM_LSB +: 4];
  assign usb_limit   = cfg_q.src_limits[CCLS_USB_LIM_LSB +: 4];

  ccls_limit_sel u_limit_sel (
    .dc_present              (sense_q.dc_supply_input),
    .vbus_present            (sense_q.vbus_present),
    .autodet_en              (autodet_en),
    .dedicated_found         (sense_q.dedicated_found),
    .dminus_select_mode      (sense_q.dminus_select_mode),
    .dminus_level            (sense_q.dminus_level),
    .dc_source_limit         (dc_limit),
    .dedicated_charger_limit (usb_limit),
    .active_input_limit      (buck_limit),
    .limit_code              (sel_limit)
  );

  // halve the limit code while the input sags
  assign reduced_limit = sense_q.vin_below_threshold ? {1'b0, sel_limit[3:1]} : sel_limit; // RQ5

  // state: load otp once after reset, then run
  always_comb begin
    case (state_q)
      CCLS_ST_LOAD: state_d = CCLS_ST_RUN;
      CCLS_ST_RUN:  state_d = CCLS_ST_RUN;
      default:      state_d = CCLS_ST_LOAD;
    endcase
  end

  // register bank next value
  always_comb begin
    cfg_d = cfg_q;
    if (state_q == CCLS_ST_LOAD) begin
      cfg_d = otp_defaults; // RQ17
    end else begin
      if (wr_buck) begin
        cfg_d.buck_ctrl = reg_wdata; // RQ10 RQ15
      end
      if (wr_src) begin
        cfg_d.src_limits = reg_wdata;
      end
      if (wr_bat) begin
        cfg_d.bat_curr = reg_wdata;
      end
      if (wr_volt) begin
        cfg_d.volt_ctrl = reg_wdata;
      end
      // dc presence overrides a host write of the buck limit
      if (sense_q.dc_supply_input) begin
        cfg_d.buck_ctrl[CCLS_BUCK_LIM_LSB +: 4] = dc_limit; // RQ1
      end
    end
  end

  // read data, one cycle after the read strobe
  assign rdata_d = !reg_read ? rdata_q :
                   hit_buck  ? cfg_q.buck_ctrl :
                   hit_src   ? cfg_q.src_limits :
                   hit_bat   ? cfg_q.bat_curr :
                   hit_volt  ? cfg_q.volt_ctrl :
                               CCLS_RDATA_UNMAPPED;

  // outputs toward the charger analog
  always_comb begin
    ctl_d = '0;
    if (running) begin
      ctl_d.input_limit                    = reduced_limit;
      ctl_d.limit_reduced                  = sense_q.vin_below_threshold; // RQ5
      ctl_d.buck_enable                    = buck_en_bit;
      ctl_d.buck_sleep_select              = sleep_sel; // RQ4
      ctl_d.thermal_current_control_enable = therm_en; // RQ14
      ctl_d.usb_autodetect_run             = autodet_en & sense_q.vbus_present; // RQ15
      ctl_d.charger_active                 = buck_en_bit & sense_q.battery_temperature_pin; // RQ13
      ctl_d.precharge_current              = cfg_q.bat_curr[CCLS_PRE_LSB +: 2]; // RQ6
      ctl_d.nominal_charge_current         = cfg_q.bat_curr[CCLS_NOM_LSB +: 6]; // RQ7
      ctl_d.target_charge_voltage          = cfg_q.volt_ctrl[CCLS_TGT_LSB +: 5]; // RQ8
      ctl_d.input_voltage_threshold        = cfg_q.volt_ctrl[CCLS_THR_LSB +: 3]; // RQ5
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= CCLS_ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_q <= {CCLS_RST_BUCK_CTRL, CCLS_RST_SRC_LIMITS, CCLS_RST_BAT_CURR, CCLS_RST_VOLT_CTRL};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sense_q <= '0;
    end else begin
      sense_q <= sense;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_q <= CCLS_RDATA_UNMAPPED;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_read;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= running; // RQ17
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign cfg_ready  = ready_q;
  assign ctl        = ctl_q;

endmodule
`default_nettype wire

// [src/ccls_pkg.sv]
/*
  ccls_pkg: register indices, field positions, reset values and carrier
  types for the charger configuration bank and input limit selection.
  assumes: consumers import the whole package; no other dependencies.
*/
package ccls_pkg;

  // register indices as seen on the serial control port
  localparam logic [7:0] CCLS_IDX_BUCK_CTRL  = 8'h3e;
  localparam logic [7:0] CCLS_IDX_SRC_LIMITS = 8'h40;
  localparam logic [7:0] CCLS_IDX_BAT_CURR   = 8'h41;
  localparam logic [7:0] CCLS_IDX_VOLT_CTRL  = 8'h42;

  // charger_buck_control fields
  localparam int CCLS_THERM_EN_BIT   = 7;
  localparam int CCLS_AUTODET_BIT    = 6;
  localparam int CCLS_SLEEP_BIT      = 5;
  localparam int CCLS_BUCK_EN_BIT    = 4;
  localparam int CCLS_BUCK_LIM_LSB   = 0;
  // source_current_limits fields
  localparam int CCLS_DC_LIM_LSB     = 4;
  localparam int CCLS_USB_LIM_LSB    = 0;
  // battery_charge_currents fields
  localparam int CCLS_PRE_LSB        = 6;
  localparam int CCLS_NOM_LSB        = 0;
  // charge_voltage_control fields
  localparam int CCLS_TGT_LSB        = 3;
  localparam int CCLS_THR_LSB        = 0;

  // values held before the one-time-programmable load
  localparam logic [7:0] CCLS_RST_BUCK_CTRL  = 8'h00;
  localparam logic [7:0] CCLS_RST_SRC_LIMITS = 8'h00;
  localparam logic [7:0] CCLS_RST_BAT_CURR   = 8'h00;
  localparam logic [7:0] CCLS_RST_VOLT_CTRL  = 8'h00;
  localparam logic [7:0] CCLS_RDATA_UNMAPPED = 8'h00;

  // configuration image, also the shape of the otp default word
  typedef struct packed {
    logic [7:0] buck_ctrl;
    logic [7:0] src_limits;
    logic [7:0] bat_curr;
    logic [7:0] volt_ctrl;
  } ccls_cfg_t;

  // supply and detection status from the analog side
  typedef struct packed {
    logic dc_supply_input;
    logic vbus_present;
    logic dedicated_found;
    logic dminus_select_mode;
    logic dminus_level;
    logic vin_below_threshold;
    logic battery_temperature_pin;
  } ccls_sense_t;

  // controls driven to the charger analog
  typedef struct packed {
    logic [3:0] input_limit;
    logic       limit_reduced;
    logic       buck_enable;
    logic       buck_sleep_select;
    logic       thermal_current_control_enable;
    logic       usb_autodetect_run;
    logic       charger_active;
    logic [1:0] precharge_current;
    logic [5:0] nominal_charge_current;
    logic [4:0] target_charge_voltage;
    logic [2:0] input_voltage_threshold;
  } ccls_ctl_t;

  typedef enum logic [1:0] {
    CCLS_ST_LOAD = 2'b01,
    CCLS_ST_RUN  = 2'b10
  } ccls_state_t;

endpackage

// [src/ccls_limit_sel.sv]
/*
  ccls_limit_sel: combinational choice of the input current limit code
  among the dc, dedicated-charger and buck limit fields.
  assumes: inputs are registered by the caller; result is registered there.
*/
`timescale 1ns/10ps
`default_nettype none
module ccls_limit_sel
  import ccls_pkg::*;
(
  input  wire logic        dc_present,
  input  wire logic        vbus_present,
  input  wire logic        autodet_en,
  input  wire logic        dedicated_found,
  input  wire logic        dminus_select_mode,
  input  wire logic        dminus_level,
  input  wire logic [3:0]  dc_source_limit,
  input  wire logic [3:0]  dedicated_charger_limit,
  input  wire logic [3:0]  active_input_limit,
  output logic      [3:0]  limit_code
);

  wire pick_usb_detect;
  wire pick_usb_pin;
  wire pick_usb;

  assign pick_usb_detect = vbus_present & autodet_en & dedicated_found; // RQ2 RQ10
  // d- used as a select pin: high picks usb limit, low the buck limit
  assign pick_usb_pin    = vbus_present & dminus_select_mode & dminus_level; // RQ16
  assign pick_usb        = pick_usb_detect | pick_usb_pin;

  // dc first, then dedicated charger, else standard port
  assign limit_code = dc_present ? dc_source_limit : // RQ1
                      pick_usb   ? dedicated_charger_limit : // RQ2
                                   active_input_limit; // RQ3

endmodule
`default_nettype wire

// [tb/ccls_props.sv]
/* ccls_props: port checks for ccls_charger_cfg.
   assumes: bound to the top module; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module ccls_props
  import ccls_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire ccls_sense_t sense,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        cfg_ready,
  input wire ccls_ctl_t   ctl
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic mapped = reg_addr inside {CCLS_IDX_BUCK_CTRL, CCLS_IDX_SRC_LIMITS,
                                       CCLS_IDX_BAT_CURR, CCLS_IDX_VOLT_CTRL};
  reset_clear_a: assert property (disable iff (1'b0) !resetn |=> ctl == '0 && !cfg_ready)
    else $error("outputs not cleared in reset");
  ready_seq_a: assert property ($rose(resetn) |-> !cfg_ready[*2] ##1 cfg_ready)
    else $error("ready timing wrong");
  read_answer_a: assert property (cfg_ready && reg_read |=> reg_rvalid)
    else $error("read not answered");
  unmapped_zero_a: assert property (cfg_ready && reg_read && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved");
  buck_write_a: assert property (cfg_ready && reg_write && reg_addr == CCLS_IDX_BUCK_CTRL
    ##1 !reg_write |=> ctl.buck_sleep_select == $past(reg_wdata[5], 2))
    else $error("sleep bit not applied");
  bat_write_a: assert property (cfg_ready && reg_write && reg_addr == CCLS_IDX_BAT_CURR
    ##1 !reg_write |=> ctl.nominal_charge_current == $past(reg_wdata[5:0], 2))
    else $error("nominal current not applied");
  volt_write_a: assert property (cfg_ready && reg_write && reg_addr == CCLS_IDX_VOLT_CTRL
    ##1 !reg_write |=> ctl.target_charge_voltage == $past(reg_wdata[7:3], 2))
    else $error("target voltage not applied");
  reduce_follow_a: assert property (cfg_ready && $past(cfg_ready, 2)
    |-> ctl.limit_reduced == $past(sense.vin_below_threshold, 2))
    else $error("reduction does not follow input");
  active_cause_a: assert property (ctl.charger_active
    |-> ctl.buck_enable && $past(sense.battery_temperature_pin, 2))
    else $error("charger active without cause");
  autodet_vbus_a: assert property (ctl.usb_autodetect_run |-> $past(sense.vbus_present, 2))
    else $error("detection without vbus");
  cover property (cfg_ready && reg_read && !mapped);
  cover property (cfg_ready && sense.dc_supply_input);
  cover property (ctl.charger_active);
endmodule
`default_nettype wire

// [tb/ccls_host.sv]
/* ccls_host: host processor model on the register port.
   assumes: caller sits 1 ns after a rising edge between calls. */
`timescale 1ns/10ps
`default_nettype none
module ccls_host (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [7:0] reg_addr,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
  end
  // host decides the detect bit by what it writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clock);
    #1 reg_write = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge clock);
    #1 reg_read = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
/* tb: self-checking bench for ccls_charger_cfg against a register model.
   assumes: ccls_pkg, ccls_host and ccls_props compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ccls_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  ccls_cfg_t   otp;
  ccls_sense_t sense = '0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, w;
  logic        reg_write, reg_read, reg_rvalid, cfg_ready, v;
  ccls_ctl_t   ctl;
  logic [7:0]  m [4];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  localparam logic [7:0] IDX [4] = '{CCLS_IDX_BUCK_CTRL, CCLS_IDX_SRC_LIMITS,
                                     CCLS_IDX_BAT_CURR, CCLS_IDX_VOLT_CTRL};
  ccls_charger_cfg u_ccls_charger_cfg (.clock(clock), .resetn(resetn), .otp_defaults(otp),
    .sense(sense), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cfg_ready(cfg_ready), .ctl(ctl));
  ccls_host u_ccls_host (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [3:0] lim();
    logic [3:0] l;
    if (sense.dc_supply_input)
      l = m[1][7:4];
    else if (sense.vbus_present && ((m[0][6] && sense.dedicated_found)
             || (sense.dminus_select_mode && sense.dminus_level)))
      l = m[1][3:0];
    else
      l = m[0][3:0];
    return sense.vin_below_threshold ? l >> 1 : l;
  endfunction
  task automatic chk_ctl();
    repeat (3) @(posedge clock);
    #1 chk("ctl", 32'({lim(), sense.vin_below_threshold, m[0][4], m[0][5], m[0][7],
      m[0][6] & sense.vbus_present, m[0][4] & sense.battery_temperature_pin, m[2], m[3]}),
      32'(ctl));
  endtask
  task automatic rdchk(input int i);
    u_ccls_host.rd(IDX[i], d, v);
    chk("reg", 32'(m[i]), 32'(d));
    chk("rvalid", 32'h1, 32'(v));
  endtask
  initial begin
    otp = $urandom(76008);
    otp.buck_ctrl = 8'hd2;
    m = '{otp.buck_ctrl, otp.src_limits, otp.bat_curr, otp.volt_ctrl};
    repeat (8) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("ready", 32'h1, 32'(cfg_ready));
    for (int i = 0; i < 4; i++) rdchk(i);
    u_ccls_host.rd(8'h3f, d, v);
    chk("unmapped", 32'h0, 32'(d));
    chk_ctl();
    $display("test load done");
    for (int k = 0; k < 12; k++) begin
      w = 8'($urandom);
      u_ccls_host.wr(IDX[k % 4], w);
      m[k % 4] = w;
      rdchk(k % 4);
      chk_ctl();
    end
    u_ccls_host.wr(8'h43, 8'hff);
    for (int i = 0; i < 4; i++) rdchk(i);
    $display("test write done");
    for (int k = 0; k < 32; k++) begin
      sense = 7'($urandom);
      w = 8'($urandom);
      u_ccls_host.wr(IDX[0], w);
      m[0] = w;
      if (sense.dc_supply_input) m[0][3:0] = m[1][7:4];
      chk_ctl();
      rdchk(0);
    end
    $display("test select done");
    sense = '0;
    resetn = 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("ctl in reset", 32'h0, 32'({ctl, cfg_ready}));
    resetn = 1'b1;
    m = '{otp.buck_ctrl, otp.src_limits, otp.bat_curr, otp.volt_ctrl};
    repeat (3) @(posedge clock);
    #1 chk("ready", 32'h1, 32'(cfg_ready));
    for (int i = 0; i < 4; i++) rdchk(i);
    chk_ctl();
    $display("test reset done");
    summarize();
  end
endmodule
bind ccls_charger_cfg ccls_props u_ccls_props (.clock(clock), .resetn(resetn),
  .sense(sense), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .cfg_ready(cfg_ready), .ctl(ctl));
`default_nettype wire
